/* File: logic/svm_regs.vh */
// Register map, field positions, reset values and timing for the supply monitor
`ifndef SVM_REGS_VH
`define SVM_REGS_VH

// Register bus geometry
`define SVM_ADDR_W           4
`define SVM_DATA_W           8

// Register offsets
`define SVM_OFF_CONTROL      4'h0
`define SVM_OFF_MFI          4'h1
`define SVM_OFF_IRQ_STATUS   4'h2
`define SVM_OFF_IRQ_MASK     4'h3

// Supply monitor control fields
`define SVM_CTL_THR_LSB      0
`define SVM_CTL_THR_MSB      2
`define SVM_CTL_ENABLE_BIT   4
`define SVM_CTL_FLAG_BIT     5

// Multi-function interrupt register fields
`define SVM_MFI_ENABLE_BIT   0
`define SVM_MFI_FLAG_BIT     4

// Event status and mask fields
`define SVM_EVT_LOW_BIT      0
`define SVM_EVT_IRQSET_BIT   1
`define SVM_EVT_SETTLED_BIT  2
`define SVM_EVT_W            3

// Reset values
`define SVM_RST_THR          3'h0
`define SVM_RST_ENABLE       1'h0
`define SVM_RST_MFI_ENABLE   1'h0
`define SVM_RST_MFI_FLAG     1'h0
`define SVM_RST_EVT          3'h0

// Timing
`define SVM_CLK_NS           8
`define SVM_SETTLE_US        100
`define SVM_QUALIFY_US       60
// Cycle counts of the two delays above at the 8 ns clock
`define SVM_SETTLE_CYC       16'd12500
`define SVM_QUALIFY_CYC      16'd7500
`define SVM_CNT_W            16

`endif

/* File: logic/svm_delay.v */
// Qualifying delay: done rises after run has held high for LIMIT cycles
`default_nettype none

module svm_delay #(
  parameter             CNT_W = 16,
  parameter [CNT_W-1:0] LIMIT = 16'h0001
) (
  input  wire core_clk_i,
  input  wire rst_n_i,
  input  wire run_i,
  output reg  done_o
);

  reg  [CNT_W-1:0] count;

  // Any drop of run restarts the wait from zero
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      count  <= {CNT_W{1'b0}};
      done_o <= 1'b0;
    end else if (!run_i) begin
      count  <= {CNT_W{1'b0}};
      done_o <= 1'b0;
    end else if (!done_o) begin
      if (count == LIMIT - {{(CNT_W-1){1'b0}}, 1'b1}) begin
        done_o <= 1'b1;
      end else begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // svm_delay

`default_nettype wire

/* File: logic/svm_top.v */
// Supply monitor control, low-supply flag, qualified request and wake-up
//
// Overview of operation
// - Detector powered only while the enable bit is one; clearing it powers off.
// - Three-bit threshold field picks one of eight rising trip voltages.
// - Low-supply flag reads one while the detector is powered and supply is below the selected threshold.
// - In sleep the detector is held off whatever the enable bit says.
// - Request flag is set by hardware only after the flag stays high the qualify delay; a write of one to its bit also sets it.
// - Request leaves through a multi-function interrupt, not a primary vector.
// - A request newly set by hardware wakes the device out of idle; one set by a write does not.
// - Request flag and its enable bit share the multi-function register.
`include "svm_regs.vh"
`default_nettype none

module svm_top #(
  parameter [`SVM_CNT_W-1:0] SETTLE_CYC  = `SVM_SETTLE_CYC,
  parameter [`SVM_CNT_W-1:0] QUALIFY_CYC = `SVM_QUALIFY_CYC
) (
  input  wire                   core_clk_i,
  input  wire                   rst_n_i,
  // Register port
  input  wire [`SVM_ADDR_W-1:0] reg_addr_i,
  input  wire [`SVM_DATA_W-1:0] reg_wdata_i,
  input  wire                   reg_wr_i,
  input  wire                   reg_rd_i,
  output reg  [`SVM_DATA_W-1:0] reg_rdata_o,
  // Analog comparator side
  input  wire                   comp_low_i,
  output reg                    detector_power_o,
  output reg  [2:0]             trip_voltage_o,
  // Power state from the system controller
  input  wire                   sleep_i,
  input  wire                   idle_i,
  // Towards the interrupt controller and power manager
  output reg                    mfi_request_o,
  output reg                    wake_o,
  output reg                    irq_o
);

  // ---------------------------------------------------------------
  // Comparator output synchroniser
  // ---------------------------------------------------------------
  reg                   comp_meta;
  reg                   comp_sync;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= comp_low_i;
      comp_sync <= comp_meta;
    end
  end

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  wire                  wr_control;
  wire                  wr_mfi;
  wire                  wr_status;
  wire                  wr_mask;

  assign wr_control = reg_wr_i && (reg_addr_i == `SVM_OFF_CONTROL);
  assign wr_mfi     = reg_wr_i && (reg_addr_i == `SVM_OFF_MFI);
  assign wr_status  = reg_wr_i && (reg_addr_i == `SVM_OFF_IRQ_STATUS);
  assign wr_mask    = reg_wr_i && (reg_addr_i == `SVM_OFF_IRQ_MASK);

  // ---------------------------------------------------------------
  // Supply monitor control register
  // ---------------------------------------------------------------
  reg                   detector_enable;
  reg  [2:0]            threshold_select;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      detector_enable  <= `SVM_RST_ENABLE;
      threshold_select <= `SVM_RST_THR;
    end else if (wr_control) begin
      detector_enable  <= reg_wdata_i[`SVM_CTL_ENABLE_BIT];
      threshold_select <=
        reg_wdata_i[`SVM_CTL_THR_MSB:`SVM_CTL_THR_LSB];
    end
  end

  // Sleep overrides the enable bit
  wire                  detector_active;

  assign detector_active = detector_enable && !sleep_i;

  // Code 0 is the lowest trip level, code 7 the highest
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      detector_power_o <= 1'b0;
      trip_voltage_o   <= `SVM_RST_THR;
    end else begin
      detector_power_o <= detector_active;
      trip_voltage_o   <= threshold_select;
    end
  end

  // ---------------------------------------------------------------
  // Low-supply flag
  // ---------------------------------------------------------------
  // An unpowered comparator output is meaningless, so it reads zero.
  // No hysteresis or filtering: slow drift near the threshold gives
  // repeated transitions.
  wire                  low_supply_flag;

  assign low_supply_flag = comp_sync && detector_active;

  // ---------------------------------------------------------------
  // Settle and qualify timers
  // ---------------------------------------------------------------
  wire                  settled;
  wire                  qualified;

  // Informs software that the settle time after enabling has passed
  svm_delay #(
    .CNT_W (`SVM_CNT_W),
    .LIMIT (SETTLE_CYC)
  ) u_settle (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (detector_active),
    .done_o     (settled)
  );

  // The flag must hold high for the whole qualify time
  svm_delay #(
    .CNT_W (`SVM_CNT_W),
    .LIMIT (QUALIFY_CYC)
  ) u_qualify (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (low_supply_flag),
    .done_o     (qualified)
  );

  // ---------------------------------------------------------------
  // Edge detection on internal levels
  // ---------------------------------------------------------------
  reg                   low_flag_d;
  reg                   settled_d;
  reg                   qualified_d;
  wire                  low_rise;
  wire                  settled_rise;
  wire                  qualify_rise;

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      low_flag_d  <= 1'b0;
      settled_d   <= 1'b0;
      qualified_d <= 1'b0;
    end else begin
      low_flag_d  <= low_supply_flag;
      settled_d   <= settled;
      qualified_d <= qualified;
    end
  end

  assign low_rise     = low_supply_flag && !low_flag_d;
  assign settled_rise = settled && !settled_d;
  assign qualify_rise = qualified && !qualified_d;

  // ---------------------------------------------------------------
  // Multi-function interrupt register: enable and request flag
  // ---------------------------------------------------------------
  reg                   low_supply_irq_enable;
  reg                   low_supply_irq_flag;
  reg                   next_irq_flag;
  wire                  hw_flag_set;

  // Hardware sets the flag once per qualified low-supply episode
  assign hw_flag_set = qualify_rise;

  always @* begin
    next_irq_flag = low_supply_irq_flag;
    if (wr_mfi) begin
      next_irq_flag = reg_wdata_i[`SVM_MFI_FLAG_BIT];
    end
    // A hardware set in the same cycle beats a software clear
    if (hw_flag_set) begin
      next_irq_flag = 1'b1;
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      low_supply_irq_enable <= `SVM_RST_MFI_ENABLE;
      low_supply_irq_flag   <= `SVM_RST_MFI_FLAG;
    end else begin
      if (wr_mfi) begin
        low_supply_irq_enable <= reg_wdata_i[`SVM_MFI_ENABLE_BIT];
      end
      low_supply_irq_flag <= next_irq_flag;
    end
  end

  // Only a fresh hardware set may wake; a flag already high does not
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wake_o        <= 1'b0;
      mfi_request_o <= 1'b0;
    end else begin
      wake_o        <= hw_flag_set && !low_supply_irq_flag
                       && idle_i;
      mfi_request_o <= next_irq_flag
                       && low_supply_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // Event status and mask
  // ---------------------------------------------------------------
  reg  [`SVM_EVT_W-1:0] evt_status;
  reg  [`SVM_EVT_W-1:0] evt_mask;
  reg  [`SVM_EVT_W-1:0] next_evt_status;
  wire [`SVM_EVT_W-1:0] evt_set;

  assign evt_set = {settled_rise, hw_flag_set, low_rise};

  always @* begin
    next_evt_status = evt_status;
    if (wr_status) begin
      next_evt_status = evt_status & ~reg_wdata_i[`SVM_EVT_W-1:0];
    end
    next_evt_status = next_evt_status | evt_set;
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      evt_status <= `SVM_RST_EVT;
      evt_mask   <= `SVM_RST_EVT;
      irq_o      <= 1'b0;
    end else begin
      evt_status <= next_evt_status;
      if (wr_mask) begin
        evt_mask <= reg_wdata_i[`SVM_EVT_W-1:0];
      end
      irq_o <= |(next_evt_status & (wr_mask ?
               reg_wdata_i[`SVM_EVT_W-1:0] : evt_mask));
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  reg  [`SVM_DATA_W-1:0] next_rdata;

  always @* begin
    next_rdata = {`SVM_DATA_W{1'b0}};
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SVM_OFF_CONTROL: begin
          next_rdata[`SVM_CTL_THR_MSB:`SVM_CTL_THR_LSB] = threshold_select;
          next_rdata[`SVM_CTL_ENABLE_BIT] = detector_enable;
          next_rdata[`SVM_CTL_FLAG_BIT]   = low_supply_flag;
        end
        `SVM_OFF_MFI: begin
          next_rdata[`SVM_MFI_ENABLE_BIT] = low_supply_irq_enable;
          next_rdata[`SVM_MFI_FLAG_BIT]   = low_supply_irq_flag;
        end
        `SVM_OFF_IRQ_STATUS: begin
          next_rdata[`SVM_EVT_W-1:0] = evt_status;
        end
        `SVM_OFF_IRQ_MASK: begin
          next_rdata[`SVM_EVT_W-1:0] = evt_mask;
        end
        default: begin
          next_rdata = {`SVM_DATA_W{1'b0}};
        end
      endcase
    end
  end

  // Data stand only in the cycle after the read strobe
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= {`SVM_DATA_W{1'b0}};
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule // svm_top

`default_nettype wire

/* File: test/svm_top_props.sv */
// Port-level checker for the supply monitor
`default_nettype none
module svm_top_props #(
  parameter [15:0] QUALIFY_CYC = 16'h0001
) (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       comp_low_i,
  input wire logic       detector_power_o,
  input wire logic       sleep_i,
  input wire logic       idle_i,
  input wire logic       mfi_request_o,
  input wire logic       wake_o,
  input wire logic       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        en;
  logic        mfi_en;
  logic [2:0]  mask;
  logic [15:0] low_cnt;
  // Shadows of the written enables and mask, tracked from the bus alone, and a run count of comp_low_i cycles
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      en <= 1'b0;
      mfi_en <= 1'b0;
      mask <= 3'h0;
      low_cnt <= 16'h0000;
    end else begin
      if (reg_wr_i && reg_addr_i == 4'h0) en <= reg_wdata_i[4];
      if (reg_wr_i && reg_addr_i == 4'h1) mfi_en <= reg_wdata_i[0];
      if (reg_wr_i && reg_addr_i == 4'h3) mask <= reg_wdata_i[2:0];
      if (!comp_low_i) low_cnt <= 16'h0000;
      else if (low_cnt != 16'hffff) low_cnt <= low_cnt + 16'h0001;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_power_on: assert property ((en && !sleep_i) |=> detector_power_o)
    else $error("detector not powered while enabled");
  a_power_off: assert property ((!en || sleep_i) |=> !detector_power_o)
    else $error("detector powered while disabled or asleep");
  a_sleep_quiet: assert property (sleep_i[*4] |-> !wake_o)
    else $error("wake while asleep");
  a_wake_qualified: assert property (wake_o |->
    $past(idle_i) && low_cnt >= QUALIFY_CYC)
    else $error("wake before qualifying delay or outside idle");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake longer than one cycle");
  a_mfi_gated: assert property (mfi_request_o |->
    mfi_en || $past(mfi_en))
    else $error("request forwarded while its enable is clear");
  a_irq_masked: assert property (irq_o |-> mask != 3'h0 || $past(mask) != 3'h0)
    else $error("interrupt with all events masked");
  a_rdata_quiet: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
endmodule // svm_top_props
`default_nettype wire

/* File: test/test_svm_top.sv */
// Self-checking bench for the supply monitor
`default_nettype none
module test_svm_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 5;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       comp_low_i = 1'b0;
  logic       detector_power_o;
  logic [2:0] trip_voltage_o;
  logic       sleep_i = 1'b0;
  logic       idle_i = 1'b0;
  logic       mfi_request_o;
  logic       wake_o;
  logic       irq_o;
  int         fails = 0;
  int         comparisons = 0;
  int         wakes = 0;
  int         seed = 32'h8f3a;
  int         n;
  logic [7:0] v;
  logic [7:0] d;
  svm_top #(.SETTLE_CYC(16'h0008), .QUALIFY_CYC(16'h0005)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .comp_low_i(comp_low_i),
    .detector_power_o(detector_power_o), .trip_voltage_o(trip_voltage_o),
    .sleep_i(sleep_i), .idle_i(idle_i), .mfi_request_o(mfi_request_o),
    .wake_o(wake_o), .irq_o(irq_o));
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (wake_o === 1'b1) wakes <= wakes + 1;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] dat);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= dat;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    q = reg_rdata_o;
  endtask
  task automatic end_of_test;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    // Reset values, the last address is unmapped
    for (int a = 0; a < 5; a++) begin
      rd(a[3:0], v);
      chk(v, 8'h00);
    end
    // Every threshold code, enable bit clear, random junk in the other bits
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[2:0] = i[2:0];
      d[4] = 1'b0;
      wr(4'h0, d);
      rd(4'h0, v);
      chk(v, {5'h00, i[2:0]});
      chk({5'h00, trip_voltage_o}, {5'h00, i[2:0]});
    end
    wr(4'h0, 8'h10);
    settle(2);
    chk({7'h0, detector_power_o}, 8'h01);
    sleep_i <= 1'b1;
    comp_low_i <= 1'b1;
    settle(4);
    chk({7'h0, detector_power_o}, 8'h00);
    rd(4'h0, v);
    chk(v, 8'h10);
    comp_low_i <= 1'b0;
    sleep_i <= 1'b0;
    wr(4'h1, 8'h01);
    wr(4'h3, 8'h07);
    idle_i <= 1'b1;
    // Short low spells near the threshold never qualify
    repeat (2) begin
      comp_low_i <= 1'b1;
      settle(3);
      comp_low_i <= 1'b0;
      settle(3);
    end
    chk({7'h0, mfi_request_o}, 8'h00);
    comp_low_i <= 1'b1;
    settle(3);
    rd(4'h0, v);
    chk(v, 8'h30);
    for (n = 3; n < 40 && mfi_request_o !== 1'b1; n++) settle(1);
    chk({7'h0, n >= Q && n <= Q + 6}, 8'h01);
    chk({7'h0, wake_o}, 8'h01);
    rd(4'h1, v);
    chk(v, 8'h11);
    rd(4'h2, v);
    chk(v, 8'h07);
    chk({7'h0, irq_o}, 8'h01);
    wr(4'h3, 8'h00);
    settle(1);
    chk({7'h0, irq_o}, 8'h00);
    wr(4'h2, 8'h07);
    wr(4'h3, 8'h07);
    settle(2);
    chk({7'h0, irq_o}, 8'h00);
    // Flag sets with its enable clear, then a preset flag blocks wake
    for (int k = 0; k < 2; k++) begin
      comp_low_i <= 1'b0;
      settle(4);
      wr(4'h1, k ? 8'h10 : 8'h00);
      settle(1);
      wakes = 0;
      comp_low_i <= 1'b1;
      settle(Q + 8);
      rd(4'h1, v);
      chk(v, 8'h10);
      chk({7'h0, mfi_request_o}, 8'h00);
      chk(wakes[7:0], k ? 8'h00 : 8'h01);
    end
    wr(4'h0, 8'h00);
    settle(2);
    chk({7'h0, detector_power_o}, 8'h00);
    rd(4'h0, v);
    chk(v, 8'h00);
    end_of_test;
  end
endmodule // test_svm_top
bind svm_top svm_top_props #(.QUALIFY_CYC(QUALIFY_CYC)) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .comp_low_i(comp_low_i),
  .detector_power_o(detector_power_o), .sleep_i(sleep_i), .idle_i(idle_i),
  .mfi_request_o(mfi_request_o), .wake_o(wake_o), .irq_o(irq_o));
`default_nettype wire
